// File: demod_params.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 50 MHz system clock
// Notes: definitions only
`ifndef DEMOD_PARAMS_SVH
`define DEMOD_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ 64'd50000000
`define REC_CLK_RATE_HZ 64'd384000
`define NCO_INC_CALC ((`REC_CLK_RATE_HZ * 64'd65536) / `CLK_HZ)
`define AFC_START_CYCLES 64
// ----------------------------------------
// register map
// ----------------------------------------
`define REG_CFG_OFS 4'h0
`define REG_STATUS_OFS 4'h4
`define REG_FREQ_OFS 4'h8
`define CFG_THRESH_LSB 0
`define CFG_SMALL_LSB 8
`define CFG_LARGE_LSB 12
`define CFG_THRESH_RST 8'h08
`define CFG_SMALL_RST 4'h2
`define CFG_LARGE_RST 4'h6
`define STAT_SLOT_LSB 0
`define STAT_FAST_BIT 2
`define STAT_WAIT_BIT 3
`define STAT_RUN_BIT 4
`define STAT_RUNEN_BIT 5
// ----------------------------------------
// serial control port
// ----------------------------------------
`define SER_ADDR_W 3
`define SER_NUM_BYTES 6
`endif

// File: demod_pkg.sv
// Purpose: shared types of the receive control block
// Assumes: nothing
// Notes: constants live in demod_params.svh
package demod_pkg;
  typedef enum logic [2:0]
  {
    AFC_HOLD = 3'b001,
    AFC_WAIT = 3'b010,
    AFC_RUN = 3'b100
  } afc_state_e;
  typedef logic [1:0] slot_t;
  typedef logic signed [15:0] freq_t;
endpackage

// File: slot_clock_recovery.sv
// Purpose: one per-slot clock recovery dpll
// Assumes: phase_err and sym_valid are on clk
// Notes: free-runs when not selected
`timescale 1ns/1ps
`include "demod_params.svh"
module slot_clock_recovery
  import demod_pkg::*;
#(
  parameter logic [15:0] NCO_INC = 16'(`NCO_INC_CALC)
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic selected,
  input wire logic sym_valid,
  input wire logic signed [7:0] phase_err,
  input wire logic fast_level,
  input wire logic fast_start,
  input wire logic run_en,
  input wire freq_t freq_corr,
  input wire logic [7:0] thresh,
  output logic clk_out,
  output logic edge_strobe,
  output logic fast_mode
);
  logic [15:0] acc_q;
  logic fast_q;
  logic clk_q;
  logic edge_q;
  logic [7:0] err_mag;
  logic signed [15:0] err_ext;
  logic signed [15:0] step;

  assign err_mag = phase_err[7] ? 8'(-phase_err) : phase_err;
  assign err_ext = {{8{phase_err[7]}}, phase_err};

  always_comb
  begin
    step = freq_corr;
    if (selected && run_en && sym_valid)
    begin
      step = fast_q ? 16'(freq_corr + (err_ext <<< 3)) : 16'(freq_corr + (err_ext >>> 1));
    end
  end

  // nco: frequency held correction always applied
  always_ff @(posedge clk or posedge rst)
    if (rst)
      acc_q <= 16'h0000;
    else
      acc_q <= 16'(acc_q + NCO_INC + step); // RL11

  always_ff @(posedge clk or posedge rst)
    if (rst)
      fast_q <= 1'b0;
    else if (!fast_level)
      fast_q <= 1'b0; // RL6
    else if (fast_start)
      fast_q <= 1'b1; // RL4
    else if (selected && sym_valid && err_mag < thresh)
      fast_q <= 1'b0; // RL5

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      clk_q <= 1'b0;
      edge_q <= 1'b0;
    end
    else
    begin
      clk_q <= acc_q[15];
      edge_q <= acc_q[15] & ~clk_q;
    end

  assign clk_out = clk_q;
  assign edge_strobe = edge_q;
  assign fast_mode = fast_q;
endmodule

// File: serial_ctrl_port.sv
// Purpose: four-wire serial access to the 6-byte control register
// Assumes: shift clock runs only while serial_enable is high
// Notes: frame is read flag, address, then 8 data bits
`timescale 1ns/1ps
`include "demod_params.svh"
module serial_ctrl_port
#(
  parameter int ADDR_W = `SER_ADDR_W,
  parameter int NUM_BYTES = `SER_NUM_BYTES,
  parameter bit MSB_FIRST = 1'b1
)
(
  input wire logic rst,
  input wire logic serial_enable,
  input wire logic serial_shift_clock,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe
);
  localparam int HDR = ADDR_W + 1;
  localparam int TOT = HDR + 8;
  logic frame_rst;
  logic [4:0] cnt_q;
  logic [ADDR_W:0] hdr_q;
  logic [7:0] in_q;
  logic [7:0] out_q;
  logic oe_q;
  logic [7:0] ctrl_q [NUM_BYTES];
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0] rd_byte;
  logic [7:0] wr_byte;

  // frame logic ends with the enable, since the clock stops
  assign frame_rst = rst | ~serial_enable;
  assign rd_addr = {hdr_q[ADDR_W-2:0], serial_data_in};
  assign wr_byte = MSB_FIRST ? {in_q[6:0], serial_data_in} : {serial_data_in, in_q[7:1]};

  always_comb
  begin
    rd_byte = 8'h00;
    if (32'(rd_addr) < NUM_BYTES)
    begin
      for (int i = 0; i < 8; i++)
        rd_byte[i] = MSB_FIRST ? ctrl_q[rd_addr][i] : ctrl_q[rd_addr][7-i];
    end
  end

  always_ff @(posedge serial_shift_clock or posedge frame_rst)
    if (frame_rst)
    begin
      cnt_q <= 5'h00;
      hdr_q <= '0;
      in_q <= 8'h00;
      out_q <= 8'h00;
      oe_q <= 1'b0;
    end
    else if (32'(cnt_q) < TOT)
    begin
      cnt_q <= 5'(cnt_q + 5'h01);
      if (32'(cnt_q) < HDR)
        hdr_q <= {hdr_q[ADDR_W-1:0], serial_data_in}; // RL16
      else
        in_q <= MSB_FIRST ? {in_q[6:0], serial_data_in} : {serial_data_in, in_q[7:1]};
      if (32'(cnt_q) == HDR - 1)
      begin
        oe_q <= hdr_q[ADDR_W-1]; // RL14
        out_q <= rd_byte;
      end
      else
        out_q <= {out_q[6:0], 1'b0};
    end

  always_ff @(posedge serial_shift_clock or posedge rst)
    if (rst)
    begin
      for (int i = 0; i < NUM_BYTES; i++)
        ctrl_q[i] <= 8'h00;
    end
    else if (serial_enable && 32'(cnt_q) == TOT - 1 && !hdr_q[ADDR_W])
    begin
      if (32'(hdr_q[ADDR_W-1:0]) < NUM_BYTES)
        ctrl_q[hdr_q[ADDR_W-1:0]] <= wr_byte; // RL12
    end

  assign serial_data_out = out_q[7];
  assign serial_data_out_oe = oe_q;
endmodule

// File: demod_slot_clock_recovery_ctrl.sv
// Purpose: receive slot clock recovery and frequency tracking control
// Assumes: rx_phase_err, rx_sym_valid, rx_data_in come from clk logic
// Notes: control pins are asynchronous and are synchronised
// Operation
// RL1: slot pins 00,01,10,11 pick slots one to four.
// RL2: four recovery circuits and four stored frequency contexts; selected one used.
// RL3: receive data and clock come from the selected circuit.
// RL4: fast acquire high starts the selected circuit in fast mode.
// RL5: fast mode drops to slow once phase error is under threshold.
// RL6: fast acquire low keeps the circuit in slow mode.
// RL7: tracking and fast acquire both high clear the selected context.
// RL8: after a clear, frequency control waits a fixed cycle count.
// RL9: small averaging count when fast acquire high, large when low.
// RL10: tracking low stops new error; held value keeps correcting.
// RL11: run enable low stops all dpll phase corrections.
// RL12: 6-byte control register, written and read over the serial port.
// RL13: processor drives enable, shift clock, address and data in.
// RL14: read data returns on the serial data output.
// RL15: phase threshold and start delay are parameters.
// RL16: serial bit order, address width and clock edge are configurable; the code always shifts on the rising edge.
`timescale 1ns/1ps
`include "demod_params.svh"
module demod_slot_clock_recovery_ctrl
  import demod_pkg::*;
#(
  parameter int AFC_START_CYCLES = `AFC_START_CYCLES,
  parameter int SER_ADDR_W = `SER_ADDR_W,
  parameter bit SER_MSB_FIRST = 1'b1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic slot_select_low,
  input wire logic slot_select_high,
  input wire logic fast_acquire_ctrl,
  input wire logic freq_track_enable,
  input wire logic recovery_run_enable,
  input wire logic rx_sym_valid,
  input wire logic signed [7:0] rx_phase_err,
  input wire logic rx_data_in,
  output logic rx_data_out,
  output logic recovered_clock_out,
  input wire logic serial_enable,
  input wire logic serial_shift_clock,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe
);
  localparam int DLY_W = $clog2(AFC_START_CYCLES + 1);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [4:0] pin_meta_q;
  logic [4:0] pin_sync_q;
  slot_t slot;
  logic fast_lvl;
  logic track_en;
  logic run_en;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      pin_meta_q <= 5'h00;
      pin_sync_q <= 5'h00;
    end
    else
    begin
      pin_meta_q <= {recovery_run_enable, freq_track_enable, fast_acquire_ctrl,
                     slot_select_high, slot_select_low};
      pin_sync_q <= pin_meta_q;
    end

  assign slot = pin_sync_q[1:0]; // RL1
  assign fast_lvl = pin_sync_q[2];
  assign track_en = pin_sync_q[3];
  assign run_en = pin_sync_q[4];

  // ----------------------------------------
  // edge detect on synchronised levels
  // ----------------------------------------
  logic fast_lvl_q;
  logic clr_cond_q;
  slot_t slot_q;
  logic fast_start;
  logic clr_evt;
  logic slot_chg;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      fast_lvl_q <= 1'b0;
      clr_cond_q <= 1'b0;
      slot_q <= 2'h0;
    end
    else
    begin
      fast_lvl_q <= fast_lvl;
      clr_cond_q <= track_en & fast_lvl;
      slot_q <= slot;
    end

  assign fast_start = fast_lvl & ~fast_lvl_q;
  // one clear per assertion, so fast averaging can run afterwards
  assign clr_evt = track_en & fast_lvl & ~clr_cond_q;
  assign slot_chg = slot != slot_q;

  // ----------------------------------------
  // configuration register
  // ----------------------------------------
  logic [7:0] thresh_q;
  logic [3:0] small_log2_q;
  logic [3:0] large_log2_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic bus_done;

  assign bus_done = (read | write) & ~wait_q;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      thresh_q <= `CFG_THRESH_RST;
      small_log2_q <= `CFG_SMALL_RST;
      large_log2_q <= `CFG_LARGE_RST;
    end
    else if (write && bus_done && address == `REG_CFG_OFS)
    begin
      if (byteenable[0])
        thresh_q <= writedata[`CFG_THRESH_LSB +: 8]; // RL15
      if (byteenable[1])
      begin
        small_log2_q <= writedata[`CFG_SMALL_LSB +: 4];
        large_log2_q <= writedata[`CFG_LARGE_LSB +: 4];
      end
    end

  // ----------------------------------------
  // clock recovery circuits
  // ----------------------------------------
  freq_t freq_q [4];
  logic [3:0] cr_clk;
  logic [3:0] cr_edge;
  logic [3:0] cr_fast;

  for (genvar g = 0; g < 4; g++)
  begin : gen_cr
    slot_clock_recovery u_cr
    (
      .clk(clk),
      .rst(rst),
      .selected(slot == 2'(g)), // RL2
      .sym_valid(rx_sym_valid),
      .phase_err(rx_phase_err),
      .fast_level(fast_lvl),
      .fast_start(fast_start && slot == 2'(g)), // RL4
      .run_en(run_en), // RL11
      .freq_corr(freq_q[g]),
      .thresh(thresh_q), // RL5
      .clk_out(cr_clk[g]),
      .edge_strobe(cr_edge[g]),
      .fast_mode(cr_fast[g])
    );
  end

  // ----------------------------------------
  // frequency tracking engine
  // ----------------------------------------
  afc_state_e afc_q;
  logic [DLY_W-1:0] dly_q;
  logic signed [23:0] sum_q;
  logic [15:0] cnt_q;
  logic [3:0] avg_log2;
  logic [15:0] avg_last;
  logic signed [23:0] sum_next;
  logic avg_done;

  assign avg_log2 = fast_lvl ? small_log2_q : large_log2_q; // RL9
  assign avg_last = 16'((17'h00001 << avg_log2) - 17'h00001);
  assign sum_next = 24'(sum_q + {{16{rx_phase_err[7]}}, rx_phase_err});
  assign avg_done = afc_q == AFC_RUN && rx_sym_valid && cnt_q == avg_last;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      afc_q <= AFC_HOLD;
      dly_q <= '0;
    end
    else if (clr_evt)
    begin
      afc_q <= AFC_WAIT;
      dly_q <= DLY_W'(AFC_START_CYCLES); // RL8
    end
    else
    begin
      case (afc_q)
        AFC_WAIT:
        begin
          if (!track_en)
            afc_q <= AFC_HOLD;
          else if (dly_q == '0)
            afc_q <= AFC_RUN; // RL8
          else
            dly_q <= DLY_W'(dly_q - 1'b1);
        end
        AFC_RUN:
        begin
          if (!track_en)
            afc_q <= AFC_HOLD; // RL10
        end
        AFC_HOLD:
        begin
          if (track_en)
            afc_q <= AFC_RUN;
        end
        default:
          afc_q <= AFC_HOLD;
      endcase
    end

  // error averaging restarts on a clear or a slot change
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      sum_q <= 24'h000000;
      cnt_q <= 16'h0000;
    end
    else if (clr_evt || slot_chg || afc_q != AFC_RUN || avg_done)
    begin
      sum_q <= 24'h000000;
      cnt_q <= 16'h0000;
    end
    else if (rx_sym_valid)
    begin
      sum_q <= sum_next;
      cnt_q <= 16'(cnt_q + 16'h0001);
    end

  // per-slot stored correction; held value keeps steering the nco
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      for (int i = 0; i < 4; i++)
        freq_q[i] <= 16'h0000;
    end
    else if (clr_evt)
      freq_q[slot] <= 16'h0000; // RL7
    else if (avg_done && !slot_chg)
      freq_q[slot] <= 16'(freq_q[slot] + 16'(sum_next >>> avg_log2)); // RL10

  // ----------------------------------------
  // receive outputs
  // ----------------------------------------
  logic rx_data_q;
  logic rec_clk_q;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      rx_data_q <= 1'b0;
      rec_clk_q <= 1'b0;
    end
    else
    begin
      rec_clk_q <= cr_clk[slot]; // RL3
      if (cr_edge[slot])
        rx_data_q <= rx_data_in; // RL3
    end

  assign rx_data_out = rx_data_q;
  assign recovered_clock_out = rec_clk_q;

  // ----------------------------------------
  // avalon slave: one wait cycle per access
  // ----------------------------------------
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h00000000;
    case (address)
      `REG_CFG_OFS:
      begin
        rd_mux[`CFG_THRESH_LSB +: 8] = thresh_q;
        rd_mux[`CFG_SMALL_LSB +: 4] = small_log2_q;
        rd_mux[`CFG_LARGE_LSB +: 4] = large_log2_q;
      end
      `REG_STATUS_OFS:
      begin
        rd_mux[`STAT_SLOT_LSB +: 2] = slot;
        rd_mux[`STAT_FAST_BIT] = cr_fast[slot];
        rd_mux[`STAT_WAIT_BIT] = afc_q == AFC_WAIT;
        rd_mux[`STAT_RUN_BIT] = afc_q == AFC_RUN;
        rd_mux[`STAT_RUNEN_BIT] = run_en;
      end
      `REG_FREQ_OFS:
        rd_mux = 32'(signed'(freq_q[slot]));
      default:
        rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else if ((read || write) && wait_q)
    begin
      wait_q <= 1'b0;
      rdata_q <= read ? rd_mux : 32'h00000000;
    end
    else
      wait_q <= 1'b1;

  assign readdata = rdata_q;
  assign waitrequest = wait_q;

  // ----------------------------------------
  // serial control port, own clock domain
  // ----------------------------------------
  serial_ctrl_port #(
    .ADDR_W(SER_ADDR_W),
    .NUM_BYTES(`SER_NUM_BYTES),
    .MSB_FIRST(SER_MSB_FIRST)
  ) u_ser
  (
    .rst(rst),
    .serial_enable(serial_enable), // RL13
    .serial_shift_clock(serial_shift_clock),
    .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), // RL14
    .serial_data_out_oe(serial_data_out_oe)
  );
endmodule

// File: demod_ctrl_monitor.sv
// Purpose: port checks of the slot clock recovery control block
// Assumes: bound to demod_slot_clock_recovery_ctrl
// Notes: pin checks wait out the two-flop pin synchroniser
`timescale 1ns/1ps
module demod_ctrl_monitor
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic slot_select_low,
  input wire logic slot_select_high,
  input wire logic fast_acquire_ctrl,
  input wire logic freq_track_enable,
  input wire logic recovery_run_enable,
  input wire logic serial_enable,
  input wire logic serial_data_out_oe
);
  // ----------------------------------------
  // pin quiet counter
  // ----------------------------------------
  // status lags the pins, so only judge it once they sat still
  logic [4:0] pins_q;
  logic [3:0] quiet_q;
  logic [4:0] pins_now;
  logic stat_rd;
  assign pins_now = {slot_select_high, slot_select_low, recovery_run_enable,
                     fast_acquire_ctrl, freq_track_enable};
  assign stat_rd = read && !waitrequest && address == 4'h4 && quiet_q > 4'h7;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pins_q <= 5'h00;
      quiet_q <= 4'h0;
    end
    else
    begin
      pins_q <= pins_now;
      if (pins_q != pins_now)
        quiet_q <= 4'h0;
      else if (quiet_q != 4'hF)
        quiet_q <= quiet_q + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_wait_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("bus answer held too long");
  a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer missing");
  a_wait_cause: assert property (!waitrequest |-> $past(read || write))
    else $error("bus answer without request");
  a_unmapped_zero: assert property (read && !waitrequest && address == 4'hC |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_status_slot: assert property (stat_rd |-> readdata[1:0] == {slot_select_high, slot_select_low})
    else $error("slot field wrong");
  a_status_runen: assert property (stat_rd |-> readdata[5] == recovery_run_enable)
    else $error("run enable field wrong");
  a_slow_stays: assert property (stat_rd && !fast_acquire_ctrl |-> !readdata[2])
    else $error("fast mode without fast pin");
  a_oe_idle: assert property (!serial_enable && !$past(serial_enable) |-> !serial_data_out_oe)
    else $error("data out driven outside frame");
endmodule

// File: serial_host_model.sv
// Purpose: host processor on the four-wire control port
// Assumes: flag, 3 address bits, 8 data bits, msb first
// Notes: shift clock idles low and runs only inside frames
`timescale 1ns/1ps
module serial_host_model
(
  output logic serial_enable,
  output logic serial_shift_clock,
  output logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe
);
  initial
  begin
    serial_enable = 1'b0;
    serial_shift_clock = 1'b0;
    serial_data_in = 1'b0;
  end
  // one byte per frame; data bits of a read frame are junk on purpose
  task automatic frame(input logic rd, input logic [2:0] a, input logic [7:0] wd,
                       output logic [7:0] rdat, output logic oe);
    logic [11:0] bits;
    bits = {rd, a, wd};
    serial_enable = 1'b1;
    for (int i = 11; i >= 0; i--)
    begin
      serial_data_in = (rd && i < 8) ? ~serial_data_in : bits[i];
      #3;
      if (i < 8)
        rdat[i] = serial_data_out;
      if (i == 7)
        oe = serial_data_out_oe;
      serial_shift_clock = 1'b1;
      #3;
      serial_shift_clock = 1'b0;
    end
    #3;
    serial_enable = 1'b0;
    serial_data_in = ~serial_data_in;
    #6;
  endtask
endmodule

// File: demod_slot_clock_recovery_ctrl_bench.sv
// Purpose: self-checking bench of the slot clock recovery control block
// Assumes: one wait cycle per bus access, pins settle in 3 edges
// Notes: afc start delay shortened to 16 cycles
`timescale 1ns/1ps
module demod_slot_clock_recovery_ctrl_bench;
  logic clk, rst, read, write, waitrequest, rx_sym_valid, rx_data_in, rx_data_out;
  logic slot_select_low, slot_select_high, fast_acquire_ctrl, freq_track_enable;
  logic recovery_run_enable, recovered_clock_out, serial_enable, serial_shift_clock;
  logic serial_data_in, serial_data_out, serial_data_out_oe, so;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata, rd;
  logic signed [7:0] rx_phase_err;
  logic [7:0] sb;
  int error_cnt, num_checks, toggles;
  demod_slot_clock_recovery_ctrl #(.AFC_START_CYCLES(16)) DUT (.clk(clk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .slot_select_low(slot_select_low), .slot_select_high(slot_select_high),
    .fast_acquire_ctrl(fast_acquire_ctrl), .freq_track_enable(freq_track_enable),
    .recovery_run_enable(recovery_run_enable), .rx_sym_valid(rx_sym_valid),
    .rx_phase_err(rx_phase_err), .rx_data_in(rx_data_in), .rx_data_out(rx_data_out),
    .recovered_clock_out(recovered_clock_out), .serial_enable(serial_enable),
    .serial_shift_clock(serial_shift_clock), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe));
  serial_host_model host (.serial_enable(serial_enable),
    .serial_shift_clock(serial_shift_clock), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ends on the rising edge that samples waitrequest low
  task wait_ack;
    int n;
    n = 0;
    @(negedge clk);
    while (waitrequest !== 1'b0)
    begin
      n++;
      if (n > 50)
      begin
        error_cnt++;
        $display("Error at %0t: no bus answer", $time);
        report_and_stop;
      end
      @(negedge clk);
    end
    @(posedge clk);
  endtask
  task av_write(input logic [3:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    byteenable <= 4'hF;
    write <= 1'b1;
    wait_ack;
    write <= 1'b0;
    // one idle edge, so a following call never re-raises in this step
    @(posedge clk);
  endtask
  task av_read(input logic [3:0] a, output logic [31:0] d);
    address <= a;
    read <= 1'b1;
    wait_ack;
    d = readdata;
    read <= 1'b0;
    @(posedge clk);
  endtask
  // order: slot high, slot low, run enable, fast acquire, tracking
  task pins(input logic [4:0] p);
    {slot_select_high, slot_select_low, recovery_run_enable, fast_acquire_ctrl,
     freq_track_enable} <= p;
    repeat (10) @(posedge clk);
  endtask
  task syms(input logic signed [7:0] e, input int n);
    repeat (n)
    begin
      rx_phase_err <= e;
      rx_sym_valid <= 1'b1;
      @(posedge clk);
      rx_sym_valid <= 1'b0;
      @(posedge clk);
    end
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    $display("Error at %0t: run too long", $time);
    report_and_stop;
  end
  initial
  begin
    {rst, read, write, rx_sym_valid, rx_data_in} = 5'h10;
    {slot_select_low, slot_select_high, fast_acquire_ctrl} = 3'h0;
    {freq_track_enable, recovery_run_enable} = 2'h0;
    {address, byteenable, writedata, rx_phase_err} = 48'h0;
    error_cnt = 0;
    num_checks = 0;
    toggles = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    av_read(4'h0, rd);
    chk(rd, 32'h0000_6208);
    av_write(4'h0, 32'h0000_5310);
    av_read(4'h0, rd);
    chk(rd, 32'h0000_5310);
    av_write(4'hC, 32'hFFFF_FFFF);
    av_read(4'hC, rd);
    chk(rd, 32'h0);
    for (int s = 0; s < 4; s++)
    begin
      pins({s[1:0], s[0], 2'b00});
      av_read(4'h4, rd);
      chk(rd & 32'h27, {26'h0, s[0], 3'b000, s[1:0]});
    end
    pins(5'b10100);
    pins(5'b10111);
    av_read(4'h4, rd);
    chk(rd & 32'h3F, 32'h2E);
    av_read(4'h8, rd);
    chk(rd, 32'h0);
    repeat (20) @(posedge clk);
    av_read(4'h4, rd);
    chk(rd & 32'h18, 32'h10);
    syms(8'sd0, 8);
    av_read(4'h4, rd);
    chk(rd & 32'h4, 32'h0);
    // small count of 8: 8 x 40 averaged gives 40
    syms(8'sd40, 8);
    av_read(4'h8, rd);
    chk(rd, 32'h28);
    pins(5'b10100);
    syms(8'sd40, 40);
    av_read(4'h8, rd);
    chk(rd, 32'h28);
    pins(5'b00100);
    av_read(4'h8, rd);
    chk(rd, 32'h0);
    pins(5'b10111);
    av_read(4'h8, rd);
    chk(rd, 32'h0);
    rx_data_in <= 1'b1;
    repeat (400)
    begin
      @(negedge clk);
      if (recovered_clock_out !== DUT.recovered_clock_out)
        toggles = 0;
      so = recovered_clock_out;
      @(negedge clk);
      if (recovered_clock_out !== so)
        toggles++;
    end
    chk({31'h0, toggles > 2}, 32'h1);
    chk({31'h0, rx_data_out}, 32'h1);
    host.frame(1'b0, 3'd2, 8'hA5, sb, so);
    host.frame(1'b1, 3'd2, 8'h00, sb, so);
    chk({24'h0, sb}, 32'hA5);
    chk({31'h0, so}, 32'h1);
    host.frame(1'b0, 3'd5, 8'h5A, sb, so);
    host.frame(1'b1, 3'd5, 8'h00, sb, so);
    chk({24'h0, sb}, 32'h5A);
    host.frame(1'b0, 3'd6, 8'hFF, sb, so);
    host.frame(1'b1, 3'd6, 8'h00, sb, so);
    chk({24'h0, sb}, 32'h0);
    report_and_stop;
  end
endmodule
bind demod_slot_clock_recovery_ctrl demod_ctrl_monitor mon (.clk(clk), .rst(rst),
  .address(address), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .slot_select_low(slot_select_low),
  .slot_select_high(slot_select_high), .fast_acquire_ctrl(fast_acquire_ctrl),
  .freq_track_enable(freq_track_enable), .recovery_run_enable(recovery_run_enable),
  .serial_enable(serial_enable), .serial_data_out_oe(serial_data_out_oe));
